//--- pci_adp_chk.sv
`default_nettype none
// ==========================================================
// wire-level checks between the two ends
module pci_adp_chk
    import pci_adp_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [AD_W-1:0] ad,
    input wire logic [CBE_W-1:0] cbe_n,
    input wire logic par,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic trdy_n,
    input wire logic m_ad_oe,
    input wire logic t_ad_oe,
    input wire logic m_cbe_oe,
    input wire logic m_par_oe,
    input wire logic t_par_oe,
    input wire logic m_frame_o,
    input wire logic m_frame_oe,
    input wire logic t_trdy_o,
    input wire logic t_trdy_oe,
    input wire logic t_serr_o,
    input wire logic t_serr_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    AST_PAR_EVEN: assert property ((m_par_oe || t_par_oe) |-> par == ^{$past(ad), $past(cbe_n)})
        else $error("parity not even over previous lines");
    AST_PAR_OWNER: assert property (m_par_oe == $past(m_ad_oe) && t_par_oe == $past(t_ad_oe))
        else $error("parity driver does not follow data owner");
    AST_FRAME_PARK: assert property ($fell(m_frame_oe) |-> $past(m_frame_o) == LINE_HIGH)
        else $error("frame released without high cycle");
    AST_TRDY_PARK: assert property ($fell(t_trdy_oe) |-> $past(t_trdy_o) == LINE_HIGH)
        else $error("target ready released without high cycle");
    AST_AD_TURN: assert property ($rose(t_ad_oe) |-> !$past(m_ad_oe))
        else $error("no idle cycle before target drives data");
    AST_AD_ONE: assert property (!(m_ad_oe && t_ad_oe))
        else $error("two drivers on address/data");
    AST_LAST_PHASE: assert property ((!irdy_n && !trdy_n) |-> frame_n ##1 irdy_n)
        else $error("frame still low at final completion");
    AST_ADDR_PHASE: assert property ($fell(frame_n) |-> m_ad_oe && m_cbe_oe ##1 m_cbe_oe)
        else $error("address phase not driven");
    AST_BE_HELD: assert property (!irdy_n |-> m_cbe_oe)
        else $error("byte enables not driven in data phase");
    AST_SERR_PULSE: assert property (t_serr_oe |-> t_serr_o == LINE_LOW ##1 !t_serr_oe)
        else $error("error line not a single low pull");
endmodule : pci_adp_chk
`default_nettype wire

//--- pci_adp_if.sv
`default_nettype none
// ==========================================================
// shared bus with pull-ups; each agent gives level and enable
interface pci_adp_if;
    import pci_adp_pkg::*;
    logic [AD_W-1:0] m_ad_o, t_ad_o, ad;
    logic m_ad_oe, t_ad_oe;
    logic [CBE_W-1:0] m_cbe_o, cbe_n;
    logic m_cbe_oe;
    logic m_par_o, m_par_oe, t_par_o, t_par_oe, par;
    logic m_frame_o, m_frame_oe, frame_n;
    logic m_irdy_o, m_irdy_oe, irdy_n;
    logic t_trdy_o, t_trdy_oe, trdy_n;
    logic t_devsel_o, t_devsel_oe, devsel_n;
    logic t_serr_o, t_serr_oe, serr_n;

    assign ad = m_ad_oe ? m_ad_o : (t_ad_oe ? t_ad_o : '1);
    assign cbe_n = m_cbe_oe ? m_cbe_o : '1;
    assign par = m_par_oe ? m_par_o : (t_par_oe ? t_par_o : LINE_HIGH);
    assign frame_n = m_frame_oe ? m_frame_o : LINE_HIGH;
    assign irdy_n = m_irdy_oe ? m_irdy_o : LINE_HIGH;
    assign trdy_n = t_trdy_oe ? t_trdy_o : LINE_HIGH;
    assign devsel_n = t_devsel_oe ? t_devsel_o : LINE_HIGH;
    assign serr_n = (t_serr_oe && (t_serr_o == LINE_LOW)) ? LINE_LOW : LINE_HIGH;

    modport master (
        output m_ad_o, m_ad_oe, m_cbe_o, m_cbe_oe, m_par_o, m_par_oe,
        output m_frame_o, m_frame_oe, m_irdy_o, m_irdy_oe,
        input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n, serr_n
    );
    modport target (
        output t_ad_o, t_ad_oe, t_par_o, t_par_oe, t_trdy_o, t_trdy_oe,
        output t_devsel_o, t_devsel_oe, t_serr_o, t_serr_oe,
        input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n
    );
endinterface : pci_adp_if
`default_nettype wire

//--- pci_adp_pkg.sv
`default_nettype none
// ==========================================================
// shared constants
package pci_adp_pkg;
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int BYTE_W = 8;
    localparam int DW_LSB = 2;
    localparam int WR_BIT = 0;
    localparam logic LINE_HIGH = 1'b1;
    localparam logic LINE_LOW = 1'b0;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [1:0] CFG_TYPE0 = 2'h0;
    localparam logic [3:0] ALL_LANES = 4'hF;
    localparam int ABORT_CLKS = 5;

    // ==========================================================
    // decoding helpers
    function automatic logic cmd_is_write(input logic [3:0] c);
        return c[WR_BIT];
    endfunction : cmd_is_write

    function automatic logic even_par(input logic [AD_W-1:0] a, input logic [CBE_W-1:0] b);
        return ^{a, b};
    endfunction : even_par
endpackage : pci_adp_pkg
`default_nettype wire

//--- pci_mst_end.sv
`default_nettype none
// ==========================================================
// single data phase bus master
module pci_mst_end
    import pci_adp_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    pci_adp_if.master bus,
    input wire logic req,
    input wire logic [3:0] req_cmd,
    input wire logic [AD_W-1:0] req_addr,
    input wire logic [AD_W-1:0] req_data,
    input wire logic [CBE_W-1:0] req_be,
    output logic busy_r,
    output logic done_r,
    output logic abort_r,
    output logic perr_r,
    output logic [AD_W-1:0] rdata_r
);
    typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_TURN, M_GAP} mstate_t;

    mstate_t state_r, state_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [AD_W-1:0] ad_o_r, ad_o_nxt, rdata_nxt, wdat_r, wdat_nxt;
    logic [CBE_W-1:0] cbe_o_r, cbe_o_nxt, be_r, be_nxt;
    logic ad_oe_r, ad_oe_nxt, cbe_oe_r, cbe_oe_nxt, par_oe_r, par_oe_nxt;
    logic frm_o_r, frm_o_nxt, frm_oe_r, frm_oe_nxt;
    logic irdy_o_r, irdy_o_nxt, irdy_oe_r, irdy_oe_nxt;
    logic [$clog2(ABORT_CLKS+1)-1:0] cnt_r, cnt_nxt;
    logic idle_q_r, rd_q_r, rd_q_nxt;
    logic busy_nxt, done_nxt, abort_nxt, perr_nxt, par_now, mism, idle;

    pci_par_unit u_par (
        .clock(clock),
        .reset_n(reset_n),
        .ad(bus.ad),
        .cbe_n(bus.cbe_n),
        .par_in(bus.par),
        .par_r(par_now),
        .mismatch(mism)
    );

    assign idle = bus.frame_n && bus.irdy_n && bus.trdy_n && bus.devsel_n;

    // ==========================================================
    // transfer sequence
    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        wdat_nxt = wdat_r;
        be_nxt = be_r;
        ad_o_nxt = ad_o_r;
        ad_oe_nxt = ad_oe_r;
        cbe_o_nxt = cbe_o_r;
        cbe_oe_nxt = cbe_oe_r;
        frm_o_nxt = frm_o_r;
        frm_oe_nxt = frm_oe_r;
        irdy_o_nxt = irdy_o_r;
        irdy_oe_nxt = irdy_oe_r;
        cnt_nxt = cnt_r;
        rdata_nxt = rdata_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        abort_nxt = 1'b0;
        rd_q_nxt = 1'b0;
        case (state_r)
            M_IDLE: begin
                if (req && idle && idle_q_r) begin
                    cmd_nxt = req_cmd;
                    wdat_nxt = req_data;
                    be_nxt = ~req_be;
                    ad_o_nxt = req_addr;
                    ad_oe_nxt = 1'b1;
                    cbe_o_nxt = req_cmd;
                    cbe_oe_nxt = 1'b1;
                    frm_o_nxt = LINE_LOW;
                    frm_oe_nxt = 1'b1;
                    busy_nxt = 1'b1;
                    state_nxt = M_ADDR;
                end
            end
            M_ADDR: begin
                frm_o_nxt = LINE_HIGH;
                irdy_o_nxt = LINE_LOW;
                irdy_oe_nxt = 1'b1;
                cbe_o_nxt = be_r;
                ad_o_nxt = wdat_r;
                ad_oe_nxt = cmd_is_write(cmd_r);
                cnt_nxt = '0;
                state_nxt = M_DATA;
            end
            M_DATA: begin
                cnt_nxt = cnt_r + 1'b1;
                if (!bus.irdy_n && !bus.trdy_n) begin
                    rdata_nxt = bus.ad;
                    done_nxt = 1'b1;
                    rd_q_nxt = !cmd_is_write(cmd_r);
                    state_nxt = M_TURN;
                end else if (bus.devsel_n && cnt_r == ($bits(cnt_r))'(ABORT_CLKS)) begin
                    abort_nxt = 1'b1;
                    state_nxt = M_TURN;
                end
                if (state_nxt == M_TURN) begin
                    frm_oe_nxt = 1'b0;
                    irdy_o_nxt = LINE_HIGH;
                    ad_oe_nxt = 1'b0;
                    cbe_oe_nxt = 1'b0;
                end
            end
            M_TURN: begin
                irdy_oe_nxt = 1'b0;
                state_nxt = M_GAP;
            end
            M_GAP: begin
                busy_nxt = 1'b0;
                state_nxt = M_IDLE;
            end
            default: state_nxt = M_IDLE;
        endcase
        par_oe_nxt = ad_oe_r;
        perr_nxt = rd_q_r && mism;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= M_IDLE;
            cmd_r <= '0;
            wdat_r <= '0;
            be_r <= '1;
            ad_o_r <= '0;
            ad_oe_r <= 1'b0;
            cbe_o_r <= '1;
            cbe_oe_r <= 1'b0;
            par_oe_r <= 1'b0;
            frm_o_r <= LINE_HIGH;
            frm_oe_r <= 1'b0;
            irdy_o_r <= LINE_HIGH;
            irdy_oe_r <= 1'b0;
            cnt_r <= '0;
            idle_q_r <= 1'b0;
            rd_q_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            abort_r <= 1'b0;
            perr_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            wdat_r <= wdat_nxt;
            be_r <= be_nxt;
            ad_o_r <= ad_o_nxt;
            ad_oe_r <= ad_oe_nxt;
            cbe_o_r <= cbe_o_nxt;
            cbe_oe_r <= cbe_oe_nxt;
            par_oe_r <= par_oe_nxt;
            frm_o_r <= frm_o_nxt;
            frm_oe_r <= frm_oe_nxt;
            irdy_o_r <= irdy_o_nxt;
            irdy_oe_r <= irdy_oe_nxt;
            cnt_r <= cnt_nxt;
            idle_q_r <= idle;
            rd_q_r <= rd_q_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            abort_r <= abort_nxt;
            perr_r <= perr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign bus.m_ad_o = ad_o_r;
    assign bus.m_ad_oe = ad_oe_r;
    assign bus.m_cbe_o = cbe_o_r;
    assign bus.m_cbe_oe = cbe_oe_r;
    assign bus.m_par_o = par_now;
    assign bus.m_par_oe = par_oe_r;
    assign bus.m_frame_o = frm_o_r;
    assign bus.m_frame_oe = frm_oe_r;
    assign bus.m_irdy_o = irdy_o_r;
    assign bus.m_irdy_oe = irdy_oe_r;
endmodule : pci_mst_end
`default_nettype wire

//--- pci_par_unit.sv
`default_nettype none
// ==========================================================
// even parity of the previous clock's bus lines, and its check
module pci_par_unit
    import pci_adp_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [AD_W-1:0] ad,
    input wire logic [CBE_W-1:0] cbe_n,
    input wire logic par_in,
    output logic par_r,
    output logic mismatch
);
    logic par_nxt;

    always_comb begin
        par_nxt = even_par(ad, cbe_n);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            par_r <= LINE_LOW;
        end else begin
            par_r <= par_nxt;
        end
    end

    assign mismatch = (par_in != par_r);
endmodule : pci_par_unit
`default_nettype wire

//--- pci_tgt_end.sv
`default_nettype none
// Functional notes
// - drive sustained line high before releasing it
// - new owner waits one clock after release
// - open-drain lines only pulled low or released
// - one address phase, then data phases
// - address phase carries 32-bit address
// - I/O byte address; memory/config dword address
// - little-endian lanes, top byte on 31:24
// - command in address phase, enables after
// - byte enables mark valid lanes all phase
// - even parity over address/data and enables
// - address parity valid one clock later
// - data parity one clock after ready
// - parity held one clock past completion
// - master parity addr/write, target parity read
// - phase completes when both readies low
// - frame starts transfer, drops in last phase
module pci_tgt_end
    import pci_adp_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter logic [AD_W-1:0] MEM_BASE = 32'h0000_1000,
    parameter logic [AD_W-1:0] IO_BASE = 32'h0000_0100
) (
    input wire logic clock,
    input wire logic reset_n,
    pci_adp_if.target bus,
    input wire logic idsel,
    output logic wr_stb_r,
    output logic [$clog2(DEPTH)-1:0] wr_idx_r,
    output logic [AD_W-1:0] wr_data_r,
    output logic [CBE_W-1:0] wr_lanes_r,
    output logic data_perr_r,
    output logic addr_perr_r
);
    localparam int IW = $clog2(DEPTH);
    localparam int HI_LSB = DW_LSB + IW;

    if (DEPTH < 2 || (1 << IW) != DEPTH) begin : g_chk
        $error("DEPTH must be a power of two, at least two");
    end

    typedef enum logic [1:0] {T_IDLE, T_WAIT, T_DATA, T_TURN} tstate_t;

    // ==========================================================
    // state
    tstate_t state_r, state_nxt;
    logic [IW-1:0] idx_r, idx_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [1:0] off_r, off_nxt;
    logic [AD_W-1:0] mem_r [DEPTH], mem_nxt [DEPTH];
    logic [AD_W-1:0] ad_o_r, ad_o_nxt;
    logic ad_oe_r, ad_oe_nxt, par_oe_r, par_oe_nxt;
    logic trdy_o_r, trdy_o_nxt, trdy_oe_r, trdy_oe_nxt;
    logic dev_o_r, dev_o_nxt, dev_oe_r, dev_oe_nxt;
    logic serr_oe_r, serr_oe_nxt;
    logic frame_q_r, aph_q_r, aph_q_nxt, wdone_q_r, wdone_q_nxt;
    logic wr_stb_nxt, dperr_nxt, aperr_nxt;
    logic [IW-1:0] wr_idx_nxt;
    logic [AD_W-1:0] wr_data_nxt;
    logic [CBE_W-1:0] wr_lanes_nxt, lanes;
    logic aph, hit, done, par_now, mism;

    // ==========================================================
    // parity
    pci_par_unit u_par (
        .clock(clock),
        .reset_n(reset_n),
        .ad(bus.ad),
        .cbe_n(bus.cbe_n),
        .par_in(bus.par),
        .par_r(par_now),
        .mismatch(mism)
    );

    // ==========================================================
    // address phase decode
    assign aph = !bus.frame_n && frame_q_r;
    assign done = !bus.irdy_n && !bus.trdy_n;

    always_comb begin
        hit = 1'b0;
        if (bus.cbe_n == CMD_MEM_RD || bus.cbe_n == CMD_MEM_WR) begin
            hit = bus.ad[AD_W-1:HI_LSB] == MEM_BASE[AD_W-1:HI_LSB];
        end else if (bus.cbe_n == CMD_IO_RD || bus.cbe_n == CMD_IO_WR) begin
            hit = bus.ad[AD_W-1:HI_LSB] == IO_BASE[AD_W-1:HI_LSB];
        end else if (bus.cbe_n == CMD_CFG_RD || bus.cbe_n == CMD_CFG_WR) begin
            hit = idsel && bus.ad[DW_LSB-1:0] == CFG_TYPE0;
        end
    end

    // io writes skip lanes below the byte address
    always_comb begin
        lanes = ~bus.cbe_n;
        if (cmd_r == CMD_IO_WR) begin
            lanes = lanes & (ALL_LANES << off_r);
        end
    end

    // ==========================================================
    // transfer sequence
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        cmd_nxt = cmd_r;
        off_nxt = off_r;
        mem_nxt = mem_r;
        ad_o_nxt = ad_o_r;
        ad_oe_nxt = ad_oe_r;
        trdy_o_nxt = trdy_o_r;
        trdy_oe_nxt = trdy_oe_r;
        dev_o_nxt = dev_o_r;
        dev_oe_nxt = dev_oe_r;
        wr_stb_nxt = 1'b0;
        wr_idx_nxt = wr_idx_r;
        wr_data_nxt = wr_data_r;
        wr_lanes_nxt = wr_lanes_r;
        wdone_q_nxt = 1'b0;
        aph_q_nxt = aph;
        case (state_r)
            T_IDLE: begin
                if (aph && hit && bus.devsel_n == LINE_HIGH) begin
                    cmd_nxt = bus.cbe_n;
                    idx_nxt = bus.ad[DW_LSB +: IW];
                    off_nxt = bus.ad[DW_LSB-1:0];
                    dev_oe_nxt = 1'b1;
                    dev_o_nxt = LINE_LOW;
                    trdy_oe_nxt = 1'b1;
                    if (cmd_is_write(bus.cbe_n)) begin
                        trdy_o_nxt = LINE_LOW;
                        state_nxt = T_DATA;
                    end else begin
                        trdy_o_nxt = LINE_HIGH;
                        state_nxt = T_WAIT;
                    end
                end
            end
            T_WAIT: begin
                ad_oe_nxt = 1'b1;
                ad_o_nxt = mem_r[idx_r];
                trdy_o_nxt = LINE_LOW;
                state_nxt = T_DATA;
            end
            T_DATA: begin
                if (done) begin
                    idx_nxt = idx_r + 1'b1;
                    if (cmd_is_write(cmd_r)) begin
                        for (int b = 0; b < CBE_W; b++) begin
                            if (lanes[b]) begin
                                mem_nxt[idx_r][b*BYTE_W +: BYTE_W] = bus.ad[b*BYTE_W +: BYTE_W];
                            end
                        end
                        wr_stb_nxt = 1'b1;
                        wr_idx_nxt = idx_r;
                        wr_data_nxt = bus.ad;
                        wr_lanes_nxt = lanes;
                        wdone_q_nxt = 1'b1;
                    end else begin
                        ad_o_nxt = mem_r[idx_r + 1'b1];
                    end
                    if (bus.frame_n) begin
                        ad_oe_nxt = 1'b0;
                        trdy_o_nxt = LINE_HIGH;
                        dev_o_nxt = LINE_HIGH;
                        state_nxt = T_TURN;
                    end
                end
            end
            T_TURN: begin
                trdy_oe_nxt = 1'b0;
                dev_oe_nxt = 1'b0;
                state_nxt = T_IDLE;
            end
            default: state_nxt = T_IDLE;
        endcase
        par_oe_nxt = ad_oe_r;
        serr_oe_nxt = aph_q_r && mism;
        aperr_nxt = aph_q_r && mism;
        dperr_nxt = wdone_q_r && mism;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= T_IDLE;
            idx_r <= '0;
            cmd_r <= '0;
            off_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            ad_o_r <= '0;
            ad_oe_r <= 1'b0;
            par_oe_r <= 1'b0;
            trdy_o_r <= LINE_HIGH;
            trdy_oe_r <= 1'b0;
            dev_o_r <= LINE_HIGH;
            dev_oe_r <= 1'b0;
            serr_oe_r <= 1'b0;
            frame_q_r <= LINE_HIGH;
            aph_q_r <= 1'b0;
            wdone_q_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_idx_r <= '0;
            wr_data_r <= '0;
            wr_lanes_r <= '0;
            data_perr_r <= 1'b0;
            addr_perr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            cmd_r <= cmd_nxt;
            off_r <= off_nxt;
            mem_r <= mem_nxt;
            ad_o_r <= ad_o_nxt;
            ad_oe_r <= ad_oe_nxt;
            par_oe_r <= par_oe_nxt;
            trdy_o_r <= trdy_o_nxt;
            trdy_oe_r <= trdy_oe_nxt;
            dev_o_r <= dev_o_nxt;
            dev_oe_r <= dev_oe_nxt;
            serr_oe_r <= serr_oe_nxt;
            frame_q_r <= bus.frame_n;
            aph_q_r <= aph_q_nxt;
            wdone_q_r <= wdone_q_nxt;
            wr_stb_r <= wr_stb_nxt;
            wr_idx_r <= wr_idx_nxt;
            wr_data_r <= wr_data_nxt;
            wr_lanes_r <= wr_lanes_nxt;
            data_perr_r <= dperr_nxt;
            addr_perr_r <= aperr_nxt;
        end
    end

    // ==========================================================
    // bus drive
    assign bus.t_ad_o = ad_o_r;
    assign bus.t_ad_oe = ad_oe_r;
    assign bus.t_par_o = par_now;
    assign bus.t_par_oe = par_oe_r;
    assign bus.t_trdy_o = trdy_o_r;
    assign bus.t_trdy_oe = trdy_oe_r;
    assign bus.t_devsel_o = dev_o_r;
    assign bus.t_devsel_oe = dev_oe_r;
    assign bus.t_serr_o = LINE_LOW;
    assign bus.t_serr_oe = serr_oe_r;
endmodule : pci_tgt_end
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench
    import pci_adp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [AD_W-1:0] MEM_B = 32'h0000_1000;
    localparam logic [AD_W-1:0] IO_B = 32'h0000_0100;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic req = 1'b0;
    logic idsel = 1'b0;
    logic [3:0] req_cmd = 4'h0;
    logic [3:0] req_be = 4'h0;
    logic [AD_W-1:0] req_addr = 32'h0;
    logic [AD_W-1:0] req_data = 32'h0;
    logic busy_r, done_r, abort_r, perr_r, wr_stb_r, data_perr_r, addr_perr_r;
    logic [AD_W-1:0] rdata_r, wr_data_r, w_data, a_ad, prev_ad;
    logic [1:0] wr_idx_r, w_idx;
    logic [3:0] wr_lanes_r, w_lanes, a_cmd, prev_cbe;
    logic f_prev = 1'b1;
    int fail_count = 0;
    int checked = 0;
    int done_cnt = 0;
    int abort_cnt = 0;
    int perr_cnt = 0;
    int tperr_cnt = 0;

    always #12.5 clock = ~clock;

    pci_adp_if bus ();
    pci_mst_end u_pci_mst_end (.clock(clock), .reset_n(reset_n), .bus(bus.master),
        .req(req), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
        .req_be(req_be), .busy_r(busy_r), .done_r(done_r), .abort_r(abort_r),
        .perr_r(perr_r), .rdata_r(rdata_r));
    pci_tgt_end #(.DEPTH(4), .MEM_BASE(MEM_B), .IO_BASE(IO_B)) u_pci_tgt_end (
        .clock(clock), .reset_n(reset_n), .bus(bus.target), .idsel(idsel),
        .wr_stb_r(wr_stb_r), .wr_idx_r(wr_idx_r), .wr_data_r(wr_data_r),
        .wr_lanes_r(wr_lanes_r), .data_perr_r(data_perr_r), .addr_perr_r(addr_perr_r));
    pci_adp_chk u_pci_adp_chk (.clock(clock), .reset_n(reset_n), .ad(bus.ad),
        .cbe_n(bus.cbe_n), .par(bus.par), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n),
        .trdy_n(bus.trdy_n), .m_ad_oe(bus.m_ad_oe), .t_ad_oe(bus.t_ad_oe),
        .m_cbe_oe(bus.m_cbe_oe), .m_par_oe(bus.m_par_oe), .t_par_oe(bus.t_par_oe),
        .m_frame_o(bus.m_frame_o), .m_frame_oe(bus.m_frame_oe), .t_trdy_o(bus.t_trdy_o),
        .t_trdy_oe(bus.t_trdy_oe), .t_serr_o(bus.t_serr_o), .t_serr_oe(bus.t_serr_oe));

    // ==========================================================
    // comparison and verdict
    task automatic check(input logic [AD_W-1:0] seen, input logic [AD_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // bus monitor: pulses, address phase, wire parity
    always @(posedge clock) begin
        if (wr_stb_r === 1'b1) begin
            w_idx <= wr_idx_r;
            w_data <= wr_data_r;
            w_lanes <= wr_lanes_r;
        end
        if (done_r === 1'b1) done_cnt <= done_cnt + 1;
        if (abort_r === 1'b1) abort_cnt <= abort_cnt + 1;
        if (perr_r === 1'b1) perr_cnt <= perr_cnt + 1;
        if (data_perr_r === 1'b1 || addr_perr_r === 1'b1 || bus.serr_n === 1'b0) begin
            tperr_cnt <= tperr_cnt + 1;
        end
        if (bus.frame_n === 1'b0 && f_prev === 1'b1) begin
            a_ad <= bus.ad;
            a_cmd <= bus.cbe_n;
        end
        if (bus.m_par_oe === 1'b1 || bus.t_par_oe === 1'b1) check(bus.par, ^{prev_ad, prev_cbe});
        f_prev <= bus.frame_n;
        prev_ad <= bus.ad;
        prev_cbe <= bus.cbe_n;
    end

    // ==========================================================
    // one request through the master, bounded waits
    task automatic do_req(input logic [3:0] cmd, input logic [AD_W-1:0] addr,
            input logic [AD_W-1:0] data, input logic [3:0] be, output logic ok);
        int n;
        int d0;
        int a0;
        d0 = done_cnt;
        a0 = abort_cnt;
        n = 0;
        req <= 1'b1;
        req_cmd <= cmd;
        req_addr <= addr;
        req_data <= data;
        req_be <= be;
        @(posedge clock);
        while (busy_r !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        req <= 1'b0;
        while ((busy_r !== 1'b0 || (done_cnt == d0 && abort_cnt == a0)) && n < 60) begin
            @(posedge clock);
            n++;
        end
        if (n >= 60) begin
            fail_count++;
            end_sim;
        end
        @(posedge clock);
        ok = (done_cnt != d0);
    endtask : do_req

    // ==========================================================
    // scenarios
    task automatic t_mem;
        logic ok;
        int p0;
        p0 = perr_cnt;
        do_req(CMD_MEM_WR, MEM_B + 32'h8, 32'hA1B2C3D4, 4'hF, ok);
        check(ok, 32'h1);
        check(a_ad, MEM_B + 32'h8);
        check(a_cmd, CMD_MEM_WR);
        check(w_idx, 32'h2);
        check(w_data, 32'hA1B2C3D4);
        do_req(CMD_MEM_WR, MEM_B + 32'h8, 32'h11223344, 4'h5, ok);
        check(w_lanes, 32'h5);
        do_req(CMD_MEM_RD, MEM_B + 32'h8, 32'h0, 4'hF, ok);
        check(a_cmd, CMD_MEM_RD);
        check(rdata_r, 32'hA122C344);
        check(perr_cnt, p0);
        check(tperr_cnt, 32'h0);
    endtask : t_mem

    task automatic t_io;
        logic ok;
        do_req(CMD_IO_WR, IO_B + 32'h5, 32'hCAFE0123, 4'hF, ok);
        check(a_ad, IO_B + 32'h5);
        check(w_idx, 32'h1);
        check(w_lanes, 32'hE);
        do_req(CMD_IO_RD, IO_B + 32'h4, 32'h0, 4'hF, ok);
        check(a_cmd, CMD_IO_RD);
        check(ok, 32'h1);
    endtask : t_io

    task automatic t_cfg;
        logic ok;
        idsel <= 1'b1;
        do_req(CMD_CFG_WR, 32'h0000000C, 32'h5A5A00FF, 4'hF, ok);
        check(w_idx, 32'h3);
        check(w_data, 32'h5A5A00FF);
        do_req(CMD_CFG_RD, 32'h0000000C, 32'h0, 4'hF, ok);
        check(rdata_r, 32'h5A5A00FF);
        idsel <= 1'b0;
        do_req(CMD_CFG_WR, 32'h0000000C, 32'h0, 4'hF, ok);
        check(ok, 32'h0);
    endtask : t_cfg

    task automatic t_miss;
        logic ok;
        do_req(CMD_MEM_RD, 32'h0000_2000, 32'h0, 4'hF, ok);
        check(ok, 32'h0);
    endtask : t_miss

    task automatic t_reset;
        int n;
        n = 0;
        req <= 1'b1;
        req_cmd <= CMD_MEM_WR;
        req_addr <= MEM_B;
        @(posedge clock);
        while (busy_r !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        if (n >= 40) begin
            fail_count++;
            end_sim;
        end
        req <= 1'b0;
        reset_n <= 1'b0;
        @(posedge clock);
        check({bus.m_ad_oe, bus.t_ad_oe, bus.m_par_oe, bus.t_par_oe, bus.m_frame_oe,
            bus.m_irdy_oe, bus.t_trdy_oe, bus.t_devsel_oe}, 32'h0);
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : t_reset

    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_mem;
        t_io;
        t_cfg;
        t_miss;
        t_reset;
        t_mem;
        end_sim;
    end
endmodule : testbench
`default_nettype wire
